/* File: rtl/ppc_pkg.sv */
package ppc_pkg;

  localparam int unsigned PPC_PINS      = 6;
  localparam int unsigned PPC_DRV_BITS  = 3;
  localparam int unsigned PPC_ADDR_W    = 8;
  localparam int unsigned PPC_DATA_W    = 32;

  // Register byte addresses on the bus
  localparam logic [7:0] PPC_OFS_DRIVE  = 8'h00;
  localparam logic [7:0] PPC_OFS_PULLEN = 8'h04;
  localparam logic [7:0] PPC_OFS_POLAR  = 8'h08;
  localparam logic [7:0] PPC_OFS_IRQEN  = 8'h0C;
  localparam logic [7:0] PPC_OFS_FLAGS  = 8'h10;

  // Field positions
  localparam int unsigned PPC_BIT_TENTH = 2;   // Reduced drive about 1/10
  localparam int unsigned PPC_BIT_FIFTH = 1;   // Bits 1..0: about 1/5
  localparam int unsigned PPC_BIT_OC    = 7;   // Over-current enable/flag
  localparam int unsigned PPC_OC_PIN    = 2;   // Port pin two

  // Implemented bits of the interrupt enable and flag registers
  localparam logic [7:0] PPC_IRQ_MASK   = 8'h BF;

  // Reset values
  localparam logic [2:0] PPC_RST_DRIVE  = 3'h0;
  localparam logic [5:0] PPC_RST_PIN6   = 6'h00;
  localparam logic [7:0] PPC_RST_BYTE   = 8'h00;

  typedef logic [1:0] ppc_resp_type;
  localparam ppc_resp_type PPC_RESP_OKAY   = 2'h0;
  localparam ppc_resp_type PPC_RESP_DECERR = 2'h3;

  typedef enum logic [2:0] {
    PPC_REG_DRIVE  = 3'h0,
    PPC_REG_PULLEN = 3'h1,
    PPC_REG_POLAR  = 3'h3,
    PPC_REG_IRQEN  = 3'h2,
    PPC_REG_FLAGS  = 3'h6,
    PPC_REG_NONE   = 3'h7
  } ppc_reg_type;

  // Address decode shared by the read and write paths
  function automatic ppc_reg_type ppc_decode(input logic [7:0] addr);
    if (addr == PPC_OFS_DRIVE) begin
      return PPC_REG_DRIVE;
    end else if (addr == PPC_OFS_PULLEN) begin
      return PPC_REG_PULLEN;
    end else if (addr == PPC_OFS_POLAR) begin
      return PPC_REG_POLAR;
    end else if (addr == PPC_OFS_IRQEN) begin
      return PPC_REG_IRQEN;
    end else if (addr == PPC_OFS_FLAGS) begin
      return PPC_REG_FLAGS;
    end else begin
      return PPC_REG_NONE;
    end
  endfunction

endpackage

/* File: rtl/ppc_sync.sv */
`timescale 1ns/100ps
module ppc_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             sys_clk,  // System clock
  input  wire logic             rst_b,    // Async reset, active low
  input  wire logic [WIDTH-1:0] async_in, // Level from outside the domain
  output logic      [WIDTH-1:0] sync_out  // Level after two flops
);
  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule // ppc_sync

/* File: rtl/ppc_edge.sv */
`timescale 1ns/100ps
module ppc_edge (
  input  wire logic sys_clk,   // System clock
  input  wire logic rst_b,     // Async reset, active low
  input  wire logic sample,    // Synchronised pin level
  input  wire logic rise_sel,  // 1 rising edge, 0 falling edge
  output logic      hit        // One-cycle active-edge pulse
);
  logic prev;
  logic primed;

  // No edge until a first real sample is held, so reset does not fake one
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      prev   <= 1'b0;
      primed <= 1'b0;
    end else begin
      prev   <= sample;
      primed <= 1'b1;
    end
  end

  always_comb begin
    hit = primed & (rise_sel ? (sample & ~prev) : (~sample & prev)); // [RL5] [RL14]
  end

  a_edge_rise: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (primed && rise_sel && sample && !prev) |-> hit) // [RL5]
    else $error("rising edge missed");
  a_edge_fall: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (hit && !rise_sel) |-> (!sample && $past(sample))) // [RL5]
    else $error("falling edge reported without a fall");
endmodule // ppc_edge

/* File: rtl/ppc_port.sv */
// Our own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
// Operation
// RL1 - Drive bit 2 set selects about one tenth drive, clear selects full.
// RL2 - Drive bits 1..0 set select about one fifth drive, clear full.
// RL3 - Drive bits act only when the pin is an output, any function.
// RL4 - Pull-enable bits 5..0 switch each pull device; ignored on outputs.
// RL5 - Polarity bit set: pulldown and rising edge; clear: pullup and falling.
// RL6 - Pin interrupt enables 5..0; detection works in any mode or function.
// RL7 - Pin flags 5..0 set on the active edge chosen by polarity.
// RL8 - Pin request only while a flag and its enable are both set.
// RL9 - Enable bit 7 unmasks the pin-two over-current interrupt.
// RL10 - Flag bit 7 sets on pin-two over-current and stays until cleared.
// RL11 - Flags readable anytime; writing 1 clears, writing 0 leaves unchanged.
// RL12 - Pull-enable register readable and writable at any time.
// RL13 - Direction bit set means output, clear means input.
// RL14 - Edges from consecutive synchronised samples; over-current synchronised level.
module ppc_port
  import ppc_pkg::*;
(
  input  wire logic                            sys_clk,          // 100 MHz clock
  input  wire logic                            rst_b,            // Async reset, low
  input  wire logic [ppc_pkg::PPC_PINS-1:0]    pin_level,        // Pad input levels
  input  wire logic [ppc_pkg::PPC_PINS-1:0]    direction_bits,   // 1 output, 0 input
  input  wire logic                            overcurrent_in,   // Pin-two over-current
  output logic [ppc_pkg::PPC_DRV_BITS-1:0]     pin_reduced_drive,// Reduced drive per pin
  output logic [ppc_pkg::PPC_PINS-1:0]         pin_pull_enable,  // Pull device on
  output logic [ppc_pkg::PPC_PINS-1:0]         pin_pull_down,    // 1 down, 0 up
  output logic                                 pin_irq_request,  // Pin interrupt
  output logic                                 overcurrent_irq_request, // Over-current irq
  input  wire logic [ppc_pkg::PPC_ADDR_W-1:0]  awaddr,           // Write address
  input  wire logic                            awvalid,          // Write address valid
  output logic                                 awready,          // Write address ready
  input  wire logic [ppc_pkg::PPC_DATA_W-1:0]  wdata,            // Write data
  input  wire logic [3:0]                      wstrb,            // Write strobes
  input  wire logic                            wvalid,           // Write data valid
  output logic                                 wready,           // Write data ready
  output ppc_pkg::ppc_resp_type                bresp,            // Write response
  output logic                                 bvalid,           // Write response valid
  input  wire logic                            bready,           // Write response ready
  input  wire logic [ppc_pkg::PPC_ADDR_W-1:0]  araddr,           // Read address
  input  wire logic                            arvalid,          // Read address valid
  output logic                                 arready,          // Read address ready
  output logic [ppc_pkg::PPC_DATA_W-1:0]       rdata,            // Read data
  output ppc_pkg::ppc_resp_type                rresp,            // Read response
  output logic                                 rvalid,           // Read data valid
  input  wire logic                            rready            // Read data ready
);
  import ppc_pkg::*;

  logic [PPC_DRV_BITS-1:0] reduced_drive_bits;
  logic [PPC_PINS-1:0]     pull_enable_bits;
  logic [PPC_PINS-1:0]     polarity_bits;
  logic [7:0]              irq_enable;
  logic [7:0]              irq_flags;
  logic [7:0]              next_irq_flags;

  logic [PPC_PINS-1:0]     pin_sync;
  logic                    oc_sync;
  logic [PPC_PINS-1:0]     edge_hit;

  logic                    aw_held;
  logic [PPC_ADDR_W-1:0]   aw_addr;
  logic                    w_held;
  logic [7:0]              w_byte;
  logic                    w_lane0;
  logic                    wr_do;
  ppc_reg_type             wr_reg;
  logic                    wr_en;
  logic [7:0]              flag_clear;
  logic [7:0]              flag_set;

  ppc_sync #(.WIDTH(PPC_PINS + 1)) u_sync (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .async_in ({overcurrent_in, pin_level}),
    .sync_out ({oc_sync, pin_sync})
  ); // [RL14]

  // Edges are taken from the pad level, so output pins and peripheral use count too
  for (genvar i = 0; i < PPC_PINS; i++) begin : g_edge
    ppc_edge u_edge (
      .sys_clk  (sys_clk),
      .rst_b    (rst_b),
      .sample   (pin_sync[i]),
      .rise_sel (polarity_bits[i]),
      .hit      (edge_hit[i])
    ); // [RL6] [RL7]
  end

  // Write channel: address and data are taken in either order
  assign awready = !aw_held;
  assign wready  = !w_held;
  assign wr_do   = aw_held && w_held && !bvalid;
  assign wr_reg  = ppc_decode(aw_addr);
  assign wr_en   = wr_do && w_lane0;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (awvalid && awready) begin
      aw_held <= 1'b1;
      aw_addr <= awaddr;
    end else if (wr_do) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      w_held  <= 1'b0;
      w_byte  <= PPC_RST_BYTE;
      w_lane0 <= 1'b0;
    end else if (wvalid && wready) begin
      w_held  <= 1'b1;
      w_byte  <= wdata[7:0];
      w_lane0 <= wstrb[0];
    end else if (wr_do) begin
      w_held  <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bvalid <= 1'b0;
      bresp  <= PPC_RESP_OKAY;
    end else if (wr_do) begin
      bvalid <= 1'b1;
      bresp  <= (wr_reg == PPC_REG_NONE) ? PPC_RESP_DECERR : PPC_RESP_OKAY;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Configuration registers, writable at any time
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reduced_drive_bits <= PPC_RST_DRIVE;
      pull_enable_bits   <= PPC_RST_PIN6;
      polarity_bits      <= PPC_RST_PIN6;
      irq_enable         <= PPC_RST_BYTE;
    end else if (wr_en) begin
      if (wr_reg == PPC_REG_DRIVE) begin
        reduced_drive_bits <= w_byte[PPC_DRV_BITS-1:0]; // [RL1] [RL2]
      end else if (wr_reg == PPC_REG_PULLEN) begin
        pull_enable_bits <= w_byte[PPC_PINS-1:0]; // [RL12]
      end else if (wr_reg == PPC_REG_POLAR) begin
        polarity_bits <= w_byte[PPC_PINS-1:0];
      end else if (wr_reg == PPC_REG_IRQEN) begin
        irq_enable <= w_byte & PPC_IRQ_MASK; // [RL6] [RL9]
      end
    end
  end

  // Flags: an event in the clearing cycle survives the clear
  always_comb begin
    flag_clear = (wr_en && wr_reg == PPC_REG_FLAGS) ? (w_byte & PPC_IRQ_MASK) : 8'h00; // [RL11]
    flag_set   = {oc_sync, 1'b0, edge_hit}; // [RL7] [RL10]
    next_irq_flags = (irq_flags & ~flag_clear) | flag_set;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_flags <= PPC_RST_BYTE;
    end else begin
      irq_flags <= next_irq_flags; // [RL10] [RL11]
    end
  end

  // Read channel, one cycle after the address is taken
  assign arready = !rvalid;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= PPC_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp  <= PPC_RESP_OKAY;
      case (ppc_decode(araddr))
        PPC_REG_DRIVE: begin
          rdata <= {{(PPC_DATA_W-PPC_DRV_BITS){1'b0}}, reduced_drive_bits};
        end
        PPC_REG_PULLEN: begin
          rdata <= {{(PPC_DATA_W-PPC_PINS){1'b0}}, pull_enable_bits}; // [RL12]
        end
        PPC_REG_POLAR: begin
          rdata <= {{(PPC_DATA_W-PPC_PINS){1'b0}}, polarity_bits};
        end
        PPC_REG_IRQEN: begin
          rdata <= {{(PPC_DATA_W-8){1'b0}}, irq_enable};
        end
        PPC_REG_FLAGS: begin
          rdata <= {{(PPC_DATA_W-8){1'b0}}, irq_flags}; // [RL11]
        end
        default: begin
          rdata <= '0;
          rresp <= PPC_RESP_DECERR;
        end
      endcase
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // Pad controls: drive strength only on outputs, pulls only on inputs
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_reduced_drive <= '0;
      pin_pull_enable   <= '0;
      pin_pull_down     <= '0;
    end else begin
      pin_reduced_drive <= reduced_drive_bits & direction_bits[PPC_DRV_BITS-1:0]; // [RL3] [RL13]
      pin_pull_enable   <= pull_enable_bits & ~direction_bits; // [RL4] [RL13]
      pin_pull_down     <= polarity_bits & pull_enable_bits & ~direction_bits; // [RL5]
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_irq_request         <= 1'b0;
      overcurrent_irq_request <= 1'b0;
    end else begin
      pin_irq_request <= |(next_irq_flags[PPC_PINS-1:0] & irq_enable[PPC_PINS-1:0]); // [RL8]
      overcurrent_irq_request <= next_irq_flags[PPC_BIT_OC] & irq_enable[PPC_BIT_OC]; // [RL9]
    end
  end

  a_pin_req_mask: assert property (@(posedge sys_clk) disable iff (!rst_b)
    pin_irq_request == |(irq_flags[PPC_PINS-1:0] & $past(irq_enable[PPC_PINS-1:0]))) // [RL8]
    else $error("pin request disagrees with flags and enables");
  a_oc_req_mask: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !$past(irq_enable[PPC_BIT_OC]) |-> !overcurrent_irq_request) // [RL9]
    else $error("masked over-current raised a request");
  a_flag_on_edge: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (edge_hit != '0)
    |=> ((irq_flags[PPC_PINS-1:0] & $past(edge_hit)) == $past(edge_hit))) // [RL7]
    else $error("edge did not set its flag");
  a_oc_sets_flag: assert property (@(posedge sys_clk) disable iff (!rst_b)
    oc_sync |=> irq_flags[PPC_BIT_OC]) // [RL10]
    else $error("over-current did not set flag");
  a_oc_flag_sticky: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (irq_flags[PPC_BIT_OC] && !flag_clear[PPC_BIT_OC]) |=> irq_flags[PPC_BIT_OC]) // [RL10]
    else $error("over-current flag dropped without a clear");
  a_zero_write_keeps: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (wr_en && wr_reg == PPC_REG_FLAGS && w_byte == 8'h00)
    |=> (($past(irq_flags) & ~irq_flags) == 8'h00)) // [RL11]
    else $error("writing zero cleared a flag");
  a_one_write_clears: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (wr_en && wr_reg == PPC_REG_FLAGS && w_byte[0] && !edge_hit[0]) |=> !irq_flags[0]) // [RL11]
    else $error("writing one did not clear pin flag");
  a_drive_out_only: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ##1 pin_reduced_drive
      == ($past(reduced_drive_bits) & $past(direction_bits[PPC_DRV_BITS-1:0]))) // [RL3]
    else $error("reduced drive reached an input pin");
  a_pull_in_only: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $past(direction_bits[0]) |-> (!pin_pull_enable[0] && !pin_pull_down[0])) // [RL4]
    else $error("pull device active on output pin");
  a_pullen_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (wr_en && wr_reg == PPC_REG_PULLEN)
    |=> pull_enable_bits == $past(w_byte[PPC_PINS-1:0])) // [RL12]
    else $error("pull enable write lost");
  a_bresp_holds: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (bvalid && !bready) |=> (bvalid && $stable(bresp)))
    else $error("write response dropped before bready");
  // Requests are registered, so they follow the enable of the cycle before
  a_oc_req_follow: assert property (@(posedge sys_clk) disable iff (!rst_b)
    overcurrent_irq_request
      == (irq_flags[PPC_BIT_OC] && $past(irq_enable[PPC_BIT_OC]))) // [RL9]
    else $error("over-current request disagrees with flag and enable");
  a_flag_needs_edge: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (irq_flags[PPC_PINS-1:0] & ~$past(irq_flags[PPC_PINS-1:0])
     & ~$past(edge_hit)) == '0) // [RL7]
    else $error("pin flag set without an active edge");
  a_pin_flag_sticky: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (~irq_flags[PPC_PINS-1:0] & $past(irq_flags[PPC_PINS-1:0])
     & ~$past(flag_clear[PPC_PINS-1:0])) == '0) // [RL11]
    else $error("pin flag dropped without a clear");
  a_oc_flag_cause: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(irq_flags[PPC_BIT_OC]) |-> $past(oc_sync)) // [RL10]
    else $error("over-current flag set without a condition");
  a_pull_in_all: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (pin_pull_enable & $past(direction_bits)) == '0) // [RL4] [RL13]
    else $error("pull device on an output pin");
  a_pull_polarity: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ((pin_pull_down ^ $past(polarity_bits)) & pin_pull_enable) == '0
    && (pin_pull_down & ~pin_pull_enable) == '0) // [RL5]
    else $error("pull direction disagrees with polarity");
  a_pullen_stable: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !(wr_en && wr_reg == PPC_REG_PULLEN) |=> $stable(pull_enable_bits)) // [RL12]
    else $error("pull enable changed without a write");
  a_drive_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (wr_en && wr_reg == PPC_REG_DRIVE)
    |=> reduced_drive_bits == $past(w_byte[PPC_DRV_BITS-1:0])) // [RL1] [RL2]
    else $error("drive strength write lost");
  a_irq_enable_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (wr_en && wr_reg == PPC_REG_IRQEN)
    |=> irq_enable == ($past(w_byte) & PPC_IRQ_MASK)) // [RL6] [RL9]
    else $error("interrupt enable write lost");
  a_strobe_ignored: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (wr_do && !w_lane0) |=> ($stable(reduced_drive_bits) && $stable(pull_enable_bits)
      && $stable(polarity_bits) && $stable(irq_enable)))
    else $error("write without lane zero changed a register");
  a_write_answer: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wr_do |=> (bvalid && !aw_held && !w_held))
    else $error("write response missing after address and data");
  a_decerr_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (wr_do && wr_reg == PPC_REG_NONE) |=> (bresp == PPC_RESP_DECERR))
    else $error("unmapped write answered without decode error");
  a_read_answer: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (arvalid && arready) |=> rvalid)
    else $error("read data missing after address");
  a_rdata_holds: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (rvalid && !rready) |=> (rvalid && $stable(rdata) && $stable(rresp)))
    else $error("read data dropped before rready");
endmodule // ppc_port

/* File: bench/ppc_pad_model.sv */
`timescale 1ns/100ps
module ppc_pad_model
  import ppc_pkg::*;
(
  input  wire logic                         sys_clk,   // System clock
  input  wire logic [ppc_pkg::PPC_PINS-1:0] pad_oe,    // Board drives the pin
  input  wire logic [ppc_pkg::PPC_PINS-1:0] pad_val,   // Level the board drives
  input  wire logic [ppc_pkg::PPC_PINS-1:0] pull_on,   // Pull device switched on
  input  wire logic [ppc_pkg::PPC_PINS-1:0] pull_down, // 1 pulldown, 0 pullup
  output logic      [ppc_pkg::PPC_PINS-1:0] pin_level  // Level seen at the pad
);
  logic [PPC_PINS-1:0] last_level;

  always_ff @(posedge sys_clk) begin
    last_level <= pin_level;
  end

  always_comb begin
    for (int i = 0; i < PPC_PINS; i++) begin
      if (pad_oe[i]) begin
        pin_level[i] = pad_val[i];
      end else if (pull_on[i]) begin
        pin_level[i] = ~pull_down[i];
      end else begin
        // Floating pin toggles, so a stale level never looks valid
        pin_level[i] = ~last_level[i];
      end
    end
  end
endmodule // ppc_pad_model

/* File: bench/ppc_port_tb_top.sv */
`timescale 1ns/100ps
module ppc_port_tb_top;
  import ppc_pkg::*;
  localparam int TIMEOUT = 5000;
  logic sys_clk = 1'b0, rst_b = 1'b0, overcurrent_in = 1'b0;
  logic [5:0] pad_oe = 6'h3F, pad_val = 6'h00, direction_bits = 6'h03, pin_level;
  logic [5:0] pin_pull_enable, pin_pull_down;
  logic [2:0] pin_reduced_drive;
  logic pin_irq_request, overcurrent_irq_request;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, d;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, awready, wvalid = 1'b0, wready, bvalid, bready = 1'b0;
  logic arvalid = 1'b0, arready, rvalid, rready = 1'b0;
  ppc_resp_type bresp, rresp, r;
  int miscompares = 0, comparisons = 0, cycles = 0;

  always #5 sys_clk = ~sys_clk;

  ppc_pad_model ppc_pad_model_inst (.sys_clk(sys_clk), .pad_oe(pad_oe), .pad_val(pad_val),
    .pull_on(pin_pull_enable), .pull_down(pin_pull_down), .pin_level(pin_level));

  ppc_port ppc_port_inst (.sys_clk(sys_clk), .rst_b(rst_b), .pin_level(pin_level),
    .direction_bits(direction_bits), .overcurrent_in(overcurrent_in),
    .pin_reduced_drive(pin_reduced_drive), .pin_pull_enable(pin_pull_enable),
    .pin_pull_down(pin_pull_down), .pin_irq_request(pin_irq_request),
    .overcurrent_irq_request(overcurrent_irq_request), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  task automatic print_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Offers address and data together, releases each once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s,
                    output ppc_resp_type resp);
    logic got;
    got = 1'b0;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!got) begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        resp = bresp;
        got = 1'b1;
        bready <= 1'b0;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output ppc_resp_type resp);
    logic got;
    got = 1'b0;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got) begin
      @(posedge sys_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        v = rdata;
        resp = rresp;
        got = 1'b1;
        rready <= 1'b0;
      end
    end
  endtask

  task automatic wr_ok(input logic [7:0] a, input logic [31:0] v);
    ppc_resp_type resp;
    wr(a, v, 4'hF, resp);
    check(32'(resp), 32'(PPC_RESP_OKAY));
  endtask

  task automatic rd_exp(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    ppc_resp_type resp;
    rd(a, v, resp);
    check(v, exp);
    check(32'(resp), 32'(PPC_RESP_OKAY));
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == TIMEOUT) begin
      miscompares++;
      print_verdict();
    end
  end

  initial begin
    logic [7:0] ofs [5];
    ofs = '{PPC_OFS_DRIVE, PPC_OFS_PULLEN, PPC_OFS_POLAR, PPC_OFS_IRQEN, PPC_OFS_FLAGS};
    tick(12);
    rst_b <= 1'b1;
    foreach (ofs[i]) rd_exp(ofs[i], 32'h0000_0000);
    rd(8'h14, d, r);
    check(32'(r), 32'(PPC_RESP_DECERR));
    check(d, 32'h0000_0000);
    wr(8'h18, 32'h0000_00FF, 4'hF, r);
    check(32'(r), 32'(PPC_RESP_DECERR));
    $display("test reset and decode done");
    wr_ok(PPC_OFS_DRIVE, 32'h0000_0007);
    rd_exp(PPC_OFS_DRIVE, 32'h0000_0007);
    tick(3);
    check(32'(pin_reduced_drive), 32'h0000_0003);
    direction_bits <= 6'h07;
    tick(3);
    check(32'(pin_reduced_drive), 32'h0000_0007);
    wr_ok(PPC_OFS_DRIVE, 32'h0000_0004);
    tick(3);
    check(32'(pin_reduced_drive), 32'h0000_0004);
    wr(PPC_OFS_DRIVE, 32'h0000_0000, 4'h0, r);
    check(32'(r), 32'(PPC_RESP_OKAY));
    rd_exp(PPC_OFS_DRIVE, 32'h0000_0004);
    $display("test drive strength done");
    direction_bits <= 6'h03;
    wr_ok(PPC_OFS_PULLEN, 32'h0000_003F);
    rd_exp(PPC_OFS_PULLEN, 32'h0000_003F);
    wr_ok(PPC_OFS_POLAR, 32'h0000_000F);
    tick(3);
    check(32'(pin_pull_enable), 32'h0000_003C);
    check(32'(pin_pull_down), 32'h0000_000C);
    $display("test pull devices done");
    pad_val <= 6'h3F;
    tick(6);
    rd_exp(PPC_OFS_FLAGS, 32'h0000_000F);
    check(32'(pin_irq_request), 32'h0000_0000);
    wr_ok(PPC_OFS_FLAGS, 32'h0000_0000);
    rd_exp(PPC_OFS_FLAGS, 32'h0000_000F);
    wr_ok(PPC_OFS_IRQEN, 32'h0000_0001);
    tick(2);
    check(32'(pin_irq_request), 32'h0000_0001);
    wr_ok(PPC_OFS_FLAGS, 32'h0000_0001);
    rd_exp(PPC_OFS_FLAGS, 32'h0000_000E);
    check(32'(pin_irq_request), 32'h0000_0000);
    direction_bits <= 6'h3F;
    pad_val <= 6'h00;
    tick(6);
    rd_exp(PPC_OFS_FLAGS, 32'h0000_003E);
    wr_ok(PPC_OFS_IRQEN, 32'h0000_0020);
    tick(2);
    check(32'(pin_irq_request), 32'h0000_0001);
    wr_ok(PPC_OFS_FLAGS, 32'h0000_003F);
    rd_exp(PPC_OFS_FLAGS, 32'h0000_0000);
    $display("test pin edges done");
    // Released pads fall back to their pulls; pull moves never hit the active edge
    direction_bits <= 6'h03;
    tick(3);
    pad_oe <= 6'h03;
    tick(6);
    wr_ok(PPC_OFS_POLAR, 32'h0000_0030);
    tick(6);
    rd_exp(PPC_OFS_FLAGS, 32'h0000_0000);
    pad_oe <= 6'h3F;
    tick(6);
    rd_exp(PPC_OFS_FLAGS, 32'h0000_000C);
    wr_ok(PPC_OFS_FLAGS, 32'h0000_000C);
    rd_exp(PPC_OFS_FLAGS, 32'h0000_0000);
    $display("test released pads done");
    wr_ok(PPC_OFS_IRQEN, 32'h0000_0080);
    overcurrent_in <= 1'b1;
    tick(6);
    overcurrent_in <= 1'b0;
    tick(6);
    rd_exp(PPC_OFS_FLAGS, 32'h0000_0080);
    check(32'(overcurrent_irq_request), 32'h0000_0001);
    wr_ok(PPC_OFS_IRQEN, 32'h0000_0000);
    tick(2);
    check(32'(overcurrent_irq_request), 32'h0000_0000);
    wr_ok(PPC_OFS_FLAGS, 32'h0000_0080);
    rd_exp(PPC_OFS_FLAGS, 32'h0000_0000);
    $display("test over-current done");
    print_verdict();
  end
endmodule // ppc_port_tb_top
